//--- logic/kbl_defines.svh
// timing and reset constants of the keyboard serial link receiver
`ifndef KBL_DEFINES_SVH
`define KBL_DEFINES_SVH

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define KBL_CODE_BITS      8
`define KBL_LAST_BIT_IDX   3'h7
`define KBL_PORT_A_RST     8'h00

// ----------------------------------------------------------------------------
// clock periods
// ----------------------------------------------------------------------------
`define KBL_SYS_PERIOD_NS  25
`define KBL_LINK_PERIOD_NS 15

// ----------------------------------------------------------------------------
// link timing
// ----------------------------------------------------------------------------
`define KBL_EDGE_GAP_NS    5000
`define KBL_RESET_HOLD_NS  10000000

`endif

//--- logic/kbl_pkg.sv
// types shared by the keyboard serial link receiver
package kbl_pkg;

  // --------------------------------------------------------------------------
  // link side phases
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LK_RECV,
    LK_ACK,
    LK_RESET
  } link_phase_t;

endpackage

//--- logic/kbl_sync2.sv
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none

module kbl_sync2 #(
  parameter int unsigned      WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t q;
  sync_state_t next_q;

  always_comb begin
    next_q        = q;
    next_q.stage1 = async_i;
    next_q.stage2 = q.stage1;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      // reset to the level the input idles at, so no false edge follows
      q.stage1 <= RESET_VAL;
      q.stage2 <= RESET_VAL;
    end else begin
      q <= next_q;
    end
  end

  assign sync_o = q.stage2;

endmodule

`default_nettype wire

//--- logic/kbl_event_xing.sv
// toggle based crossing of a one-cycle event between two clocks
`timescale 1ns/1ps
`default_nettype none

module kbl_event_xing (
  input  wire logic src_clk_i,
  input  wire logic dst_clk_i,
  input  wire logic reset_i,
  input  wire logic src_pulse_i,
  output logic      dst_pulse_o
);

  typedef struct packed {
    logic toggle;
  } src_state_t;

  typedef struct packed {
    logic last;
  } dst_state_t;

  src_state_t q_src;
  src_state_t next_q_src;
  dst_state_t q_dst;
  dst_state_t next_q_dst;
  logic       toggle_sync;

  always_comb begin
    next_q_src        = q_src;
    next_q_src.toggle = q_src.toggle ^ src_pulse_i;
  end

  always_ff @(posedge src_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_src <= '0;
    end else begin
      q_src <= next_q_src;
    end
  end

  kbl_sync2 #(
    .WIDTH (1)
  ) u_sync (
    .clk_i   (dst_clk_i),
    .reset_i (reset_i),
    .async_i (q_src.toggle),
    .sync_o  (toggle_sync)
  );

  always_comb begin
    next_q_dst      = q_dst;
    next_q_dst.last = toggle_sync;
  end

  always_ff @(posedge dst_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_dst <= '0;
    end else begin
      q_dst <= next_q_dst;
    end
  end

  assign dst_pulse_o = toggle_sync ^ q_dst.last;

endmodule

`default_nettype wire

//--- logic/keyboard_serial_link.sv
// keyboard serial link receiver: capture, acknowledge, reset, port A
//
// Functional notes
// [R01] both lines rest high when idle
// [R02] edges on the lines at least 5 us apart; only the releases back to receive wait out this gap, the pulls low and the data release on entering reset do not
// [R03] keycode is eight bits, MSB first
// [R04] one bit: data high across clock pulse
// [R05] zero bit: data low before clock falls
// [R06] data shifted in on clock falling edge
// [R07] data pulled low after eighth bit, held
// [R08] keyboard waits for data release
// [R09] keyboard reset: clock low 10 ms
// [R10] make code 0-127, break sets MSB
// [R11] held key repeats every 83 ms
// [R12] pause key never repeats
// [R13] keyboard sends 0AAh after reset
// [R14] mouse buttons give codes 7E, 7D
// [R15] joystick gives codes 7C down to 77
// [R16] code on port A, interrupt level 1
// [R17] hold code and acknowledge until read
`include "kbl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module keyboard_serial_link #(
  parameter int unsigned RESET_HOLD_CYC =
    (`KBL_RESET_HOLD_NS + `KBL_SYS_PERIOD_NS - 1) / `KBL_SYS_PERIOD_NS
) (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       link_clk_i,
  input  wire logic       ser_clk_i,
  output logic            ser_clk_o,
  output logic            ser_clk_oe_n_o,
  input  wire logic       ser_data_i,
  output logic            ser_data_o,
  output logic            ser_data_oe_n_o,
  input  wire logic       port_a_read_i,
  input  wire logic       kbd_reset_i,
  output logic [7:0]      port_a_o,
  output logic            key_irq_o,
  output logic            kbd_resetting_o
);

  // --------------------------------------------------------------------------
  // constants
  // --------------------------------------------------------------------------
  localparam int unsigned GAP_CYC_I =
    (`KBL_EDGE_GAP_NS + `KBL_LINK_PERIOD_NS - 1) / `KBL_LINK_PERIOD_NS;
  localparam int unsigned GAP_W  = $clog2(GAP_CYC_I + 1);
  localparam int unsigned HOLD_W = $clog2(RESET_HOLD_CYC + 1);
  localparam logic [GAP_W-1:0]  GAP_CYC  = GAP_W'(GAP_CYC_I);
  localparam logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'(RESET_HOLD_CYC);
  localparam logic [HOLD_W-1:0] HOLD_ONE = HOLD_W'(1);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    kbl_pkg::link_phase_t     phase;
    logic [`KBL_CODE_BITS-1:0] shreg;
    logic [2:0]               nbits;
    logic                     clk_prev;
    logic                     data_prev;
    logic                     clk_oe_n;
    logic                     data_oe_n;
    logic                     ack_seen;
    logic [GAP_W-1:0]         gap;
  } link_state_t;

  typedef struct packed {
    logic [7:0]        port_a;
    logic              irq;
    logic              hold;
    logic [HOLD_W-1:0] hold_cnt;
  } sys_state_t;

  link_state_t q_link;
  link_state_t next_q_link;
  sys_state_t  q_sys;
  sys_state_t  next_q_sys;

  logic [1:0] pins_sync;
  logic       clk_s;
  logic       data_s;
  logic       hold_s;
  logic       fall;
  logic       edge_seen;
  logic       code_done;
  logic       code_arrived;
  logic       ack_pulse;
  logic       ack_arrived;

  // --------------------------------------------------------------------------
  // crossings
  // --------------------------------------------------------------------------
  kbl_sync2 #(
    .WIDTH     (2),
    .RESET_VAL (2'h3)
  ) u_pin_sync (
    .clk_i   (link_clk_i),
    .reset_i (reset_i),
    .async_i ({ser_clk_i, ser_data_i}),
    .sync_o  (pins_sync)
  );

  kbl_sync2 #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_hold_sync (
    .clk_i   (link_clk_i),
    .reset_i (reset_i),
    .async_i (q_sys.hold),
    .sync_o  (hold_s)
  );

  kbl_event_xing u_code_xing (
    .src_clk_i   (link_clk_i),
    .dst_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .src_pulse_i (code_done),
    .dst_pulse_o (code_arrived)
  );

  kbl_event_xing u_ack_xing (
    .src_clk_i   (sys_clk_i),
    .dst_clk_i   (link_clk_i),
    .reset_i     (reset_i),
    .src_pulse_i (ack_pulse),
    .dst_pulse_o (ack_arrived)
  );

  assign clk_s  = pins_sync[1];
  assign data_s = pins_sync[0];

  // --------------------------------------------------------------------------
  // link side
  // --------------------------------------------------------------------------
  assign fall      = q_link.clk_prev & ~clk_s;
  assign edge_seen = (clk_s != q_link.clk_prev) |
                     (data_s != q_link.data_prev);
  assign code_done = (q_link.phase == kbl_pkg::LK_RECV) & ~hold_s & fall &
                     (q_link.nbits == `KBL_LAST_BIT_IDX);

  always_comb begin
    next_q_link           = q_link;
    next_q_link.clk_prev  = clk_s;
    next_q_link.data_prev = data_s;
    // time since the last edge on either line
    if (edge_seen) begin
      next_q_link.gap = '0; // [R02]
    end else if (q_link.gap < GAP_CYC) begin
      next_q_link.gap = q_link.gap + GAP_W'(1);
    end
    case (q_link.phase)
      kbl_pkg::LK_RECV: begin
        next_q_link.ack_seen = 1'b0;
        if (hold_s) begin
          next_q_link.phase    = kbl_pkg::LK_RESET;
          next_q_link.clk_oe_n = 1'b0; // [R09]
          next_q_link.nbits    = '0;
        end else if (fall) begin
          // msb arrives first, so shift toward the top
          next_q_link.shreg = {q_link.shreg[6:0], data_s}; // [R06] [R03]
          next_q_link.nbits = q_link.nbits + 3'h1;
          if (code_done) begin
            next_q_link.nbits     = '0;
            next_q_link.phase     = kbl_pkg::LK_ACK;
            next_q_link.data_oe_n = 1'b0; // [R07]
          end
        end
      end
      kbl_pkg::LK_ACK: begin
        if (ack_arrived) begin
          next_q_link.ack_seen = 1'b1;
        end
        if (hold_s) begin
          next_q_link.phase     = kbl_pkg::LK_RESET;
          next_q_link.clk_oe_n  = 1'b0; // [R09]
          next_q_link.data_oe_n = 1'b1;
          next_q_link.gap       = '0;
        end else if (q_link.ack_seen && q_link.gap >= GAP_CYC) begin
          // release only once software took the code
          next_q_link.data_oe_n = 1'b1; // [R17] [R02] [R08]
          next_q_link.phase     = kbl_pkg::LK_RECV;
          next_q_link.ack_seen  = 1'b0;
          next_q_link.gap       = '0;
        end
      end
      kbl_pkg::LK_RESET: begin
        next_q_link.ack_seen = 1'b0;
        if (!hold_s && q_link.gap >= GAP_CYC) begin
          next_q_link.clk_oe_n = 1'b1; // [R02] [R01]
          next_q_link.phase    = kbl_pkg::LK_RECV;
          next_q_link.gap      = '0;
        end
      end
      default: begin
        next_q_link = '0;
        next_q_link.phase     = kbl_pkg::LK_RECV;
        next_q_link.clk_oe_n  = 1'b1;
        next_q_link.data_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_link           <= '0;
      q_link.phase     <= kbl_pkg::LK_RECV;
      q_link.clk_prev  <= 1'b1;
      q_link.data_prev <= 1'b1;
      q_link.clk_oe_n  <= 1'b1; // [R01]
      q_link.data_oe_n <= 1'b1; // [R01]
    end else begin
      q_link <= next_q_link;
    end
  end

  // --------------------------------------------------------------------------
  // processor side
  // --------------------------------------------------------------------------
  // an arriving code wins over a read in the same cycle
  assign ack_pulse = port_a_read_i & q_sys.irq & ~code_arrived;

  always_comb begin
    next_q_sys = q_sys;
    if (code_arrived) begin
      // link holds shreg still while it acknowledges
      next_q_sys.port_a = q_link.shreg; // [R16]
      next_q_sys.irq    = 1'b1; // [R16]
    end else if (ack_pulse) begin
      next_q_sys.irq = 1'b0; // [R17]
    end
    if (kbd_reset_i && !q_sys.hold) begin
      next_q_sys.hold     = 1'b1; // [R09]
      next_q_sys.hold_cnt = HOLD_CYC;
    end else if (q_sys.hold) begin
      next_q_sys.hold_cnt = q_sys.hold_cnt - HOLD_ONE;
      if (q_sys.hold_cnt == HOLD_ONE) begin
        next_q_sys.hold = 1'b0;
      end
    end
  end

  // keyboard is also reset after every board reset
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_sys.port_a   <= `KBL_PORT_A_RST;
      q_sys.irq      <= 1'b0;
      q_sys.hold     <= 1'b1;
      q_sys.hold_cnt <= HOLD_CYC;
    end else begin
      q_sys <= next_q_sys;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign ser_clk_o       = 1'b0;
  assign ser_data_o      = 1'b0;
  assign ser_clk_oe_n_o  = q_link.clk_oe_n;
  assign ser_data_oe_n_o = q_link.data_oe_n;
  assign port_a_o        = q_sys.port_a;
  assign key_irq_o       = q_sys.irq;
  assign kbd_resetting_o = q_sys.hold;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  property p_idle_released;
    @(posedge link_clk_i) disable iff (reset_i)
      (q_link.phase == kbl_pkg::LK_RECV) |->
        (ser_clk_oe_n_o && ser_data_oe_n_o);
  endproperty
  a_idle_released: assert property (p_idle_released) // [R01]
    else $error("line driven while receiver idle");

  property p_release_gap;
    @(posedge link_clk_i) disable iff (reset_i)
      (q_link.phase != kbl_pkg::LK_RECV &&
       next_q_link.phase == kbl_pkg::LK_RECV) |-> (q_link.gap >= GAP_CYC);
  endproperty
  a_release_gap: assert property (p_release_gap) // [R02]
    else $error("line released too soon after an edge");

  property p_eight_bits;
    @(posedge link_clk_i) disable iff (reset_i)
      (q_link.phase == kbl_pkg::LK_RECV && !hold_s && fall) |=>
        (q_link.phase == kbl_pkg::LK_ACK) == ($past(q_link.nbits) == 3'h7);
  endproperty
  a_eight_bits: assert property (p_eight_bits) // [R03]
    else $error("acknowledge not after exactly eight bits");

  property p_shift_on_fall;
    @(posedge link_clk_i) disable iff (reset_i)
      (q_link.phase == kbl_pkg::LK_RECV && !hold_s && fall) |=>
        (q_link.shreg == {$past(q_link.shreg[6:0]), $past(data_s)});
  endproperty
  a_shift_on_fall: assert property (p_shift_on_fall) // [R06]
    else $error("bit not shifted in on falling clock");

  property p_ack_held;
    @(posedge link_clk_i) disable iff (reset_i)
      code_done |=> (!ser_data_oe_n_o) throughout
        (q_link.phase == kbl_pkg::LK_ACK)[*4];
  endproperty
  a_ack_held: assert property (p_ack_held) // [R07]
    else $error("data not held low after eighth bit");

  property p_reset_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
      (kbd_reset_i && !q_sys.hold) |=>
        (q_sys.hold && q_sys.hold_cnt == HOLD_CYC) ##1
        (q_sys.hold && q_sys.hold_cnt == HOLD_CYC - HOLD_ONE);
  endproperty
  a_reset_hold: assert property (p_reset_hold) // [R09]
    else $error("keyboard reset hold not started");

  property p_reset_drive;
    @(posedge link_clk_i) disable iff (reset_i)
      (hold_s && q_link.phase != kbl_pkg::LK_RESET) |=>
        (!ser_clk_oe_n_o && ser_data_oe_n_o);
  endproperty
  a_reset_drive: assert property (p_reset_drive) // [R09]
    else $error("clock not pulled low for keyboard reset");

  property p_code_to_port;
    @(posedge sys_clk_i) disable iff (reset_i)
      code_arrived |=> (key_irq_o && port_a_o == $past(q_link.shreg));
  endproperty
  a_code_to_port: assert property (p_code_to_port) // [R16]
    else $error("code not presented on port A");

  property p_hold_until_read;
    @(posedge sys_clk_i) disable iff (reset_i)
      (key_irq_o && !port_a_read_i) |=> (key_irq_o && $stable(port_a_o));
  endproperty
  a_hold_until_read: assert property (p_hold_until_read) // [R17]
    else $error("code dropped before it was read");

  c_code_received: cover property (
    @(posedge sys_clk_i) disable iff (reset_i) code_arrived);
  c_ack_released: cover property (
    @(posedge link_clk_i) disable iff (reset_i)
      q_link.phase == kbl_pkg::LK_ACK ##1 q_link.phase == kbl_pkg::LK_RECV);
  c_reset_done: cover property (
    @(posedge link_clk_i) disable iff (reset_i)
      q_link.phase == kbl_pkg::LK_RESET ##1 q_link.phase == kbl_pkg::LK_RECV);
  c_self_test: cover property (
    @(posedge sys_clk_i) disable iff (reset_i)
      code_arrived ##1 port_a_o == 8'hAA);

endmodule

`default_nettype wire

//--- sim/kbd_model.sv
// keyboard side model: frames keycodes onto the two-wire link
`timescale 1ns/1ps
`default_nettype none

module kbd_model #(
  parameter int GAP_NS       = 5000,
  parameter int RESET_MIN_NS = 10000000
) (
  input  wire logic ser_clk_i,
  input  wire logic ser_data_i,
  output logic      clk_pull_o,
  output logic      data_pull_o
);
  realtime t_low;

  // --------------------------------------------------------------------------
  // idle: both lines released to the pull-ups
  // --------------------------------------------------------------------------
  initial begin
    clk_pull_o  = 1'b0;
    data_pull_o = 1'b0;
  end

  // --------------------------------------------------------------------------
  // one keycode, msb first, every edge a gap apart
  // --------------------------------------------------------------------------
  // sends only on request, never repeats a code by itself
  task automatic send_code(input logic [7:0] code, input int lag_ns);
    wait (ser_data_i === 1'b1 && ser_clk_i === 1'b1);
    #(GAP_NS + lag_ns);
    for (int i = 7; i >= 0; i--) begin
      if (code[i]) begin
        clk_pull_o = 1'b1;
        #(GAP_NS) clk_pull_o = 1'b0;
        #(GAP_NS);
      end else begin
        data_pull_o = 1'b1;
        #(GAP_NS) clk_pull_o = 1'b1;
        #(GAP_NS) data_pull_o = 1'b0;
        #(GAP_NS) clk_pull_o = 1'b0;
        #(GAP_NS);
      end
    end
  endtask

  // --------------------------------------------------------------------------
  // long clock low from the board restarts us: report self test
  // --------------------------------------------------------------------------
  initial begin
    forever begin
      wait (ser_clk_i === 1'b0 && clk_pull_o === 1'b0);
      t_low = $realtime;
      wait (ser_clk_i === 1'b1);
      if ($realtime - t_low >= RESET_MIN_NS) begin
        send_code(8'hAA, 0);
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the keyboard serial link receiver
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int HOLD = 50;
  typedef struct {
    logic [7:0] code;
    int         lag;
    logic [7:0] exp;
  } row_t;

  logic       sys_clk;
  logic       reset;
  logic       link_clk;
  wire logic  ser_clk;
  wire logic  ser_data;
  logic       ser_clk_o;
  logic       ser_clk_oe_n;
  logic       ser_data_o;
  logic       ser_data_oe_n;
  logic       port_a_read;
  logic       kbd_reset;
  logic [7:0] port_a;
  logic       key_irq;
  logic       kbd_resetting;
  logic       clk_pull;
  logic       data_pull;
  int         errors;
  int         total_checks;
  int         n;
  row_t       rows [13];

  // wired-and with pull-ups
  assign ser_clk  = !((!ser_clk_oe_n && !ser_clk_o) || clk_pull);
  assign ser_data = !((!ser_data_oe_n && !ser_data_o) || data_pull);

  keyboard_serial_link #(.RESET_HOLD_CYC(HOLD)) dut (
    .sys_clk_i       (sys_clk),
    .reset_i         (reset),
    .link_clk_i      (link_clk),
    .ser_clk_i       (ser_clk),
    .ser_clk_o       (ser_clk_o),
    .ser_clk_oe_n_o  (ser_clk_oe_n),
    .ser_data_i      (ser_data),
    .ser_data_o      (ser_data_o),
    .ser_data_oe_n_o (ser_data_oe_n),
    .port_a_read_i   (port_a_read),
    .kbd_reset_i     (kbd_reset),
    .port_a_o        (port_a),
    .key_irq_o       (key_irq),
    .kbd_resetting_o (kbd_resetting)
  );

  kbd_model #(.RESET_MIN_NS(1000)) kbd (
    .ser_clk_i   (ser_clk),
    .ser_data_i  (ser_data),
    .clk_pull_o  (clk_pull),
    .data_pull_o (data_pull)
  );

  // --------------------------------------------------------------------------
  // clocks and watchdog
  // --------------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #7.5 link_clk = ~link_clk;
  end

  initial begin
    #2450000;
    errors++;
    close_out();
  end

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic pulse_read();
    @(posedge sys_clk);
    port_a_read <= 1'b1;
    @(posedge sys_clk);
    port_a_read <= 1'b0;
    #1;
  endtask

  task automatic take_code(input logic [7:0] exp);
    int k;
    k = 0;
    while (key_irq !== 1'b1 && k < 20000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check(port_a === exp, "received code");
    check(ser_data_oe_n === 1'b0, "data not acknowledged");
    repeat (100) @(posedge sys_clk);
    #1;
    check(key_irq === 1'b1 && port_a === exp, "code not held");
    check(ser_data_oe_n === 1'b0, "ack dropped before read");
    pulse_read();
    check(key_irq === 1'b0, "irq not cleared by read");
    k = 0;
    while (ser_data_oe_n !== 1'b1 && k < 1000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check(ser_data_oe_n === 1'b1 && ser_clk_oe_n === 1'b1, "no release");
  endtask

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    port_a_read = 1'b0;
    kbd_reset = 1'b0;
    errors = 0;
    total_checks = 0;
    rows = '{
      '{8'h7E, 0, 8'h7E}, '{8'h7D, 0, 8'h7D},
      '{8'h7C, 0, 8'h7C}, '{8'h7B, 20000, 8'h7B},
      '{8'h7A, 0, 8'h7A}, '{8'h79, 0, 8'h79},
      '{8'h78, 0, 8'h78}, '{8'h77, 0, 8'h77},
      '{8'h00, 0, 8'h00}, '{8'hFF, 0, 8'hFF},
      '{8'h05, 0, 8'h05},
      '{8'h05, 0, 8'h05},
      '{8'h85, 0, 8'h85}
    };
    repeat (10) @(posedge sys_clk);
    #1;
    check(port_a === 8'h00 && key_irq === 1'b0, "reset outputs");
    check(ser_clk_oe_n === 1'b1 && ser_data_oe_n === 1'b1, "idle");
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    take_code(8'hAA);
    foreach (rows[i]) begin
      kbd.send_code(rows[i].code, rows[i].lag);
      take_code(rows[i].exp);
    end
    pulse_read();
    check(port_a === 8'h85 && key_irq === 1'b0, "stray read acted");
    check(ser_data_oe_n === 1'b1, "stray read touched data");
    @(posedge sys_clk);
    kbd_reset <= 1'b1;
    @(posedge sys_clk);
    kbd_reset <= 1'b0;
    #1;
    check(kbd_resetting === 1'b1, "keyboard reset not started");
    n = 1;
    while (kbd_resetting === 1'b1 && n < 4 * HOLD) begin
      @(posedge sys_clk);
      kbd_reset <= (n == 10);
      #1;
      n++;
      if (n == 20) begin
        check(ser_clk_oe_n === 1'b0, "clock not held low");
      end
    end
    check(n >= HOLD && n <= HOLD + 1, "keyboard reset length");
    take_code(8'hAA);
    close_out();
  end
endmodule
`default_nettype wire
